// >>> dv/tb.sv
// Testbench joining far end and device, with a rule-breaking second port
`timescale 1ns/100ps
`include "tx_port_defines.svh"
module tb;
  import tx_port_pkg::*;
  localparam logic [4:0] MATCH = 5'h05;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  port_mode_t  mode = mode_cell;
  port_level_t level = level_2;
  logic [4:0]  target = 5'h0a;
  logic [15:0] user_data = 16'h0000;
  logic        user_start = 1'b0, user_chg = 1'b0, user_valid = 1'b0;
  logic        out_ready = 1'b0, clear = 1'b0, wide_2 = 1'b1;
  logic        user_ready, space_seen, perr, perr_2;
  logic        out_start, out_valid, out_valid_2;
  logic [4:0]  selected_port;
  logic [15:0] out_data;
  logic [16:0] q[$];
  int          cnt[5] = '{27, 5, 24, 34, 25};
  int          bad_count = 0;
  int          checks = 0;
  tx_port_if i_tx_port_if ();
  tx_port_if i_tx_port_if_2 ();
  always #5 clk = ~clk;
  tx_port_far_end i_tx_port_far_end (.clk(clk), .rst(rst),
    .bus(i_tx_port_if.far_end), .mode(mode), .target_address(target),
    .user_data(user_data), .user_start(user_start),
    .user_port_change(user_chg), .user_valid(user_valid),
    .user_ready(user_ready), .space_seen(space_seen));
  tx_port_device i_tx_port_device (.clk(clk), .rst(rst),
    .bus(i_tx_port_if.device), .mode(mode), .level(level), .multi_phy(1'b1),
    .wide_bus(1'b1), .port_address(MATCH),
    .packet_space_level(`PKT_SPACE_RST), .parity_error_clear(clear),
    .parity_error(perr), .selected_port(selected_port),
    .out_data(out_data), .out_start(out_start), .out_valid(out_valid),
    .out_ready(out_ready));
  tx_port_device i_tx_port_device_2 (.clk(clk), .rst(rst),
    .bus(i_tx_port_if_2.device), .mode(mode), .level(level),
    .multi_phy(1'b1), .wide_bus(wide_2), .port_address(MATCH),
    .packet_space_level(`PKT_SPACE_RST), .parity_error_clear(clear),
    .parity_error(perr_2), .selected_port(), .out_data(), .out_start(),
    .out_valid(out_valid_2), .out_ready(out_ready));
  tx_port_checker #(.MATCH(MATCH)) i_tx_port_checker (.clk(clk), .rst(rst),
    .data_bus(i_tx_port_if.data_bus), .parity_in(i_tx_port_if.parity_in),
    .write_enable_n(i_tx_port_if.write_enable_n),
    .start_mark(i_tx_port_if.start_mark),
    .port_change(i_tx_port_if.port_change),
    .port_address_bus(i_tx_port_if.port_address_bus),
    .space_available_o(i_tx_port_if.space_available_o),
    .space_available_oe_n(i_tx_port_if.space_available_oe_n));
  initial begin
    i_tx_port_if_2.data_bus = 16'h0000;
    i_tx_port_if_2.parity_in = 1'b0;
    i_tx_port_if_2.write_enable_n = 1'b1;
    i_tx_port_if_2.start_mark = 1'b0;
    i_tx_port_if_2.port_change = 1'b0;
    i_tx_port_if_2.port_address_bus = MATCH;
  end
  task automatic fail(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    checks++;
    if (g !== e) fail("flag differs");
  endtask
  task automatic cmp_word(input logic [16:0] g, input logic [16:0] e);
    checks++;
    if (g !== e) fail("word differs");
  endtask
  function automatic logic exp_space(port_mode_t m, int n);
    int f;
    f = `FIFO_DEPTH - (n > `FIFO_DEPTH ? `FIFO_DEPTH : n);
    return m == mode_cell ? f >= `CELL_WORDS : f >= int'(`PKT_SPACE_RST);
  endfunction
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic idle(input int k);
    user_valid <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  task automatic send(input logic [15:0] d, input logic s, input logic c);
    int n;
    user_valid <= 1'b1;
    user_data <= d;
    user_start <= s;
    user_chg <= c;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (user_ready === 1'b1) break;
    end
    if (n == 20) begin
      fail("far end never ready");
      results();
    end
  endtask
  task automatic drain();
    int n;
    out_ready <= 1'b1;
    for (n = 0; n < 200 && q.size() > 0; n++) begin
      @(negedge clk);
      if (out_valid === 1'b1) begin
        cmp_word({out_start, out_data}, q.pop_front());
      end
    end
    if (n == 200) begin
      fail("buffer never drained");
      results();
    end
    @(posedge clk);
    out_ready <= 1'b0;
  endtask
  task automatic w2(input logic [15:0] d, input logic p, input logic wn);
    @(posedge clk);
    i_tx_port_if_2.write_enable_n <= wn;
    i_tx_port_if_2.data_bus <= d;
    i_tx_port_if_2.parity_in <= p;
    @(posedge clk);
    i_tx_port_if_2.write_enable_n <= 1'b1;
    i_tx_port_if_2.data_bus <= ~d;
    i_tx_port_if_2.parity_in <= ~p;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    logic [15:0] d;
    port_mode_t  m;
    void'($urandom(9));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    send(16'h1234, 1'b1, 1'b0);
    idle(10);
    cmp_bit(i_tx_port_if.space_available_oe_n, 1'b1);
    target <= MATCH;
    for (int t = 0; t < 5; t++) begin
      m = t == 4 ? mode_chunk : t > 1 ? mode_packet : mode_cell;
      mode <= m;
      level <= port_level_t'(t % 2);
      q.delete();
      do_reset();
      for (int i = 0; i < cnt[t]; i++) begin
        d = 16'($urandom);
        send(d, i == 0, m == mode_chunk && i == 0);
        if (i < `FIFO_DEPTH) q.push_back({i == 0, d});
      end
      idle(10);
      cmp_bit(i_tx_port_if.space_available_oe_n, 1'b0);
      cmp_bit(space_seen, exp_space(m, cnt[t]));
      drain();
      idle(10);
      cmp_bit(space_seen, 1'b1);
      cmp_bit(out_valid, 1'b0);
      cmp_bit(perr, 1'b0);
      if (t == 3) begin
        d = 16'($urandom);
        send(d, 1'b0, 1'b1);
        idle(10);
        cmp_word({12'h000, selected_port}, {12'h000, d[15:11]});
      end
    end
    mode <= mode_packet;
    do_reset();
    d = 16'($urandom);
    w2(d, ~^d, 1'b1);
    cmp_bit(out_valid_2, 1'b0);
    w2(d, ^d, 1'b0);
    cmp_bit(perr_2, 1'b1);
    cmp_bit(out_valid_2, 1'b1);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    mode <= mode_other;
    w2(~d, ^d, 1'b0);
    cmp_bit(perr_2, 1'b0);
    mode <= mode_packet;
    w2(~d, ~^d, 1'b0);
    cmp_bit(perr_2, 1'b0);
    wide_2 <= 1'b0;
    w2({8'h01, d[7:0]}, ~^d[7:0], 1'b0);
    cmp_bit(perr_2, 1'b0);
    w2({8'h01, d[7:0]}, ^d[7:0], 1'b0);
    cmp_bit(perr_2, 1'b1);
    results();
  end
endmodule // tb

// >>> dv/tx_port_checker.sv
// Assertions on the pins between far end and device
`timescale 1ns/100ps
module tx_port_checker #(
  parameter logic [4:0] MATCH = 5'h05
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] data_bus,
  input wire logic        parity_in,
  input wire logic        write_enable_n,
  input wire logic        start_mark,
  input wire logic        port_change,
  input wire logic [4:0]  port_address_bus,
  input wire logic        space_available_o,
  input wire logic        space_available_oe_n
);
  logic [1:0] match_hist;
  logic [3:0] since_write;
  logic [1:0] next_match_hist;
  logic [3:0] next_since_write;
  // Cycles since the last write, and addressed writes of the last two edges
  always_comb begin
    next_match_hist  = {match_hist[0],
                        !write_enable_n && port_address_bus == MATCH};
    next_since_write = since_write + {3'h0, since_write != 4'hf};
    if (!write_enable_n) next_since_write = 4'h0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_hist  <= 2'h0;
      since_write <= 4'hf;
    end else begin
      match_hist  <= next_match_hist;
      since_write <= next_since_write;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_match_write;
    !write_enable_n && port_address_bus == MATCH;
  endsequence
  sequence s_drive_start;
    $fell(space_available_oe_n);
  endsequence
  a_parity_odd: assert property (
    !write_enable_n |-> ^{data_bus, parity_in})
    else $error("even parity on a write");
  a_start_with_write: assert property (
    start_mark |-> !write_enable_n) else $error("start without write");
  a_change_with_write: assert property (
    port_change |-> !write_enable_n) else $error("change without write");
  a_quiet_after_reset: assert property (
    $fell(rst) |-> write_enable_n && !start_mark && !port_change)
    else $error("pins busy after reset");
  a_match_then_drive: assert property (
    s_match_write |-> ##[1:2] !space_available_oe_n)
    else $error("flow output not driven after match");
  a_drive_needs_match: assert property (
    s_drive_start |-> match_hist != 2'h0)
    else $error("flow output driven without match");
  a_drive_holds: assert property (
    s_drive_start |=> !space_available_oe_n [*2])
    else $error("flow output released early");
  a_space_fall_cause: assert property (
    $fell(space_available_o) && !space_available_oe_n
      && $past(!space_available_oe_n) |-> since_write <= 4'h8)
    else $error("space fell without a write");
endmodule // tx_port_checker

// >>> hdl/tx_fifo.sv
// Flop-based FIFO with valid and ready on both sides
`timescale 1ns/100ps
module tx_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [WIDTH-1:0]       in_data,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  output logic [WIDTH-1:0]            out_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [$clog2(DEPTH+1)-1:0]  free_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready    = (count != CW'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    free_count  = CW'(DEPTH) - count;
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1)
                       : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1)
                      : rd_ptr;
    next_count  = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule // tx_fifo

// >>> hdl/tx_port_defines.svh
// Constants for the transmit cell and packet port
// Summary of operation
// - Far end drives odd parity of data
// - Device checks odd parity in both modes
// - Parity ignored in framer and HDLC modes
// - Write enable low stores data word
// - Write enable high stores nothing
// - Cell space high when one cell fits
// - Level 2: cell space driven after match
// - Level 3: cell space driven two later
// - Packet space high at or above programmed free words
// - Level 2: packet space driven after match
// - Level 3: packet space driven two later
// - Far end pulses start mark on first word
// - Start mark on packet or chunk start
// - Level 3 packet mode: port change takes upper bits as port
// - Chunk start marks packet start beat
// - Port change input used only where valid
// - Flow output driven only on address match when multi_phy is set
`ifndef TX_PORT_DEFINES_SVH
`define TX_PORT_DEFINES_SVH
`define DATA_W        16
`define ADDR_W        5
`define FIFO_DEPTH    32
`define CELL_WORDS    27
`define PORT_LSB      11
`define PORT_MSB      15
`define PORT_ADDR_RST 5'h00
`define PKT_SPACE_RST 6'h08
`endif

// >>> hdl/tx_port_device.sv
// Device end: transmit port with buffer, parity check and flow control
`timescale 1ns/100ps
`include "tx_port_defines.svh"
module tx_port_device
  import tx_port_pkg::*;
#(
  parameter int DATA_W     = `DATA_W,
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter int CELL_WORDS = `CELL_WORDS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  tx_port_if.device              bus,
  input  wire port_mode_t        mode,
  input  wire port_level_t       level,
  input  wire logic              multi_phy,
  input  wire logic              wide_bus,
  input  wire logic [4:0]        port_address,
  input  wire logic [5:0]        packet_space_level,
  input  wire logic              parity_error_clear,
  output logic                   parity_error,
  output logic [4:0]             selected_port,
  output logic [DATA_W-1:0]      out_data,
  output logic                   out_start,
  output logic                   out_valid,
  input  wire logic              out_ready
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  // Pins latched once; the far end runs on the same clock
  logic [DATA_W-1:0] data_s2;
  logic [3:0]        ctl_s2;
  logic              matched, matched_d1;
  logic              next_matched, next_matched_d1;
  logic              next_parity_error;
  logic [4:0]        next_selected_port;
  logic              active_mode, write, parity_bad, space, drive;
  logic              is_start;
  logic [CW-1:0]     free_count;
  logic [DATA_W:0]   fifo_out;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_s2 <= '0;
      ctl_s2  <= 4'h1;
    end else begin
      data_s2 <= bus.data_bus;
      ctl_s2  <= {bus.port_change, bus.start_mark, bus.parity_in,
                  bus.write_enable_n};
    end
  end

  always_comb begin
    active_mode = (mode != mode_other);
    write = active_mode && !ctl_s2[0];
    // Odd parity: data bits plus parity bit must have odd count
    parity_bad = wide_bus ? ~(^{data_s2, ctl_s2[1]})
                          : ~(^{data_s2[7:0], ctl_s2[1]});
    is_start = (mode == mode_chunk) ? (ctl_s2[2] || ctl_s2[3])
                                    : ctl_s2[2];
    next_parity_error = parity_error;
    if (parity_error_clear) begin
      next_parity_error = 1'b0;
    end
    if (write && parity_bad) begin
      next_parity_error = 1'b1;
    end
    next_selected_port = selected_port;
    if (mode == mode_packet && level == level_3 && write &&
        ctl_s2[3]) begin
      next_selected_port = data_s2[`PORT_MSB:`PORT_LSB];
    end
    next_matched = matched;
    // Match taken straight from the pins so the flag drives next cycle
    if (!bus.write_enable_n) begin
      next_matched = (bus.port_address_bus == port_address);
    end
    next_matched_d1 = matched;
    if (mode == mode_cell) begin
      space = free_count >= CW'(CELL_WORDS);
    end else begin
      space = free_count >= CW'(packet_space_level);
    end
    if (!multi_phy) begin
      drive = active_mode;
    end else if (level == level_2) begin
      drive = matched;
    end else begin
      drive = matched && matched_d1;
    end
    bus.space_available_o    = space;
    bus.space_available_oe_n = !drive;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_error  <= 1'b0;
      selected_port <= `PORT_ADDR_RST;
      matched       <= 1'b0;
      matched_d1    <= 1'b0;
    end else begin
      parity_error  <= next_parity_error;
      selected_port <= next_selected_port;
      matched       <= next_matched;
      matched_d1    <= next_matched_d1;
    end
  end

  tx_fifo #(
    .WIDTH (DATA_W+1),
    .DEPTH (FIFO_DEPTH)
  ) buffer (
    .clk        (clk),
    .rst        (rst),
    .in_data    ({is_start, data_s2}),
    .in_valid   (write),
    .in_ready   (),
    .out_data   (fifo_out),
    .out_valid  (out_valid),
    .out_ready  (out_ready),
    .free_count (free_count)
  );

  always_comb begin
    out_data  = fifo_out[DATA_W-1:0];
    out_start = fifo_out[DATA_W];
  end
endmodule // tx_port_device

// >>> hdl/tx_port_far_end.sv
// Far end: link processor side that writes words into the port
`timescale 1ns/100ps
`include "tx_port_defines.svh"
module tx_port_far_end
  import tx_port_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  tx_port_if.far_end             bus,
  input  wire port_mode_t        mode,
  input  wire logic [4:0]        target_address,
  input  wire logic [15:0]       user_data,
  input  wire logic              user_start,
  input  wire logic              user_port_change,
  input  wire logic              user_valid,
  output logic                   user_ready,
  output logic                   space_seen
);
  logic [15:0] data_q, next_data;
  logic        par_q, next_par;
  logic        en_n_q, next_en_n;
  logic        start_q, next_start;
  logic        chg_q, next_chg;
  logic [4:0]  addr_q;
  logic        sp1, sp2;
  logic        active;

  always_comb begin
    active     = (mode != mode_other);
    space_seen = sp2;
    user_ready = active;
    next_data  = user_data;
    next_par   = active && ~(^user_data);
    next_en_n  = !(user_valid && active);
    next_start = user_valid && active && user_start;
    next_chg   = user_valid && (mode == mode_packet || mode == mode_chunk)
                 && user_port_change;
    bus.data_bus         = data_q;
    bus.parity_in        = par_q;
    bus.write_enable_n   = en_n_q;
    bus.start_mark       = start_q;
    bus.port_change      = chg_q;
    bus.port_address_bus = addr_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q  <= '0;
      par_q   <= 1'b0;
      en_n_q  <= 1'b1;
      start_q <= 1'b0;
      chg_q   <= 1'b0;
      addr_q  <= '0;
      sp1     <= 1'b0;
      sp2     <= 1'b0;
    end else begin
      data_q  <= next_data;
      par_q   <= next_par;
      en_n_q  <= next_en_n;
      start_q <= next_start;
      chg_q   <= next_chg;
      addr_q  <= target_address;
      sp1     <= bus.space_available;
      sp2     <= sp1;
    end
  end
endmodule // tx_port_far_end

// >>> hdl/tx_port_if.sv
// Pins between the link processor and the transmit port
`timescale 1ns/100ps
interface tx_port_if;
  logic [15:0] data_bus;
  logic        parity_in;
  logic        write_enable_n;
  logic        start_mark;
  logic        port_change;
  logic [4:0]  port_address_bus;
  logic        space_available_o;
  logic        space_available_oe_n;
  wire         space_available;
  assign space_available = space_available_oe_n ? 1'b0 : space_available_o;
  modport device (
    input  data_bus,
    input  parity_in,
    input  write_enable_n,
    input  start_mark,
    input  port_change,
    input  port_address_bus,
    output space_available_o,
    output space_available_oe_n
  );
  modport far_end (
    output data_bus,
    output parity_in,
    output write_enable_n,
    output start_mark,
    output port_change,
    output port_address_bus,
    input  space_available
  );
endinterface

// >>> hdl/tx_port_pkg.sv
// Types for the transmit cell and packet port
package tx_port_pkg;
  typedef enum logic [1:0] {
    mode_cell,
    mode_packet,
    mode_chunk,
    mode_other
  } port_mode_t;
  typedef enum logic {
    level_2,
    level_3
  } port_level_t;
endpackage
